// ==== dv/board_model.sv ====
`timescale 1ns/1ps
// Crystal ticks and the pulled-up open-drain pin around the block
module board_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin_oe,
    output logic      osc_tick,
    output logic      pin_level
);
    logic [1:0] div_q;
    // One tick every four clocks stands in for the doubled crystal rate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) div_q <= 2'h0;
        else div_q <= div_q + 2'h1;
    end
    assign osc_tick  = (div_q == 2'h3);
    // The pull-up wins whenever the block releases the pin
    assign pin_level = pin_oe ? 1'b0 : 1'b1;
endmodule : board_model

// ==== dv/rtc_cfg_asserts.sv ====
`timescale 1ns/1ps
module rtc_cfg_asserts #(parameter int ALARM_PULSE_CYCLES = 20) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       on_battery,
    input wire logic       supply_powerup,
    input wire logic       supply_below_trip,
    input wire logic       alarm_match,
    input wire logic       irq_fout_oe,
    input wire logic [2:0] supply_trip_select,
    input wire logic [2:0] battery_trip_first_select,
    input wire logic [2:0] battery_trip_second_select,
    input wire logic       battery_disconnect,
    input wire logic       clear_switch_stamps,
    input wire logic       low_supply_flag,
    input wire logic [1:0] coarse_digital_trim,
    input wire logic [5:0] fine_analog_trim
);
    // ----------------------------------------------------------------
    // Helper logic: the pin control byte is not a port, so shadow it
    // ----------------------------------------------------------------
    logic [7:0] int_q;
    logic [1:0] age_q;
    wire w9 = reg_wr && reg_addr == 8'h09;
    wire wa = reg_wr && reg_addr == 8'h0A;
    wire [2:0] sup_c = reg_wdata[2:0] > 3'h5 ? 3'h5 : reg_wdata[2:0];
    wire [2:0] b1_c = reg_wdata[5:3] > 3'h6 ? 3'h6 : reg_wdata[5:3];
    wire [2:0] b2_c = reg_wdata[2:0] > 3'h6 ? 3'h6 : reg_wdata[2:0];
    wire [5:0] bat_c = {b1_c, b2_c};
    wire low_c = supply_below_trip && !on_battery;
    wire quiet = on_battery || int_q[3:0] != 4'h0;
    wire [7:0] trim_w = {coarse_digital_trim, fine_analog_trim};
    // Age counter keeps the trim check clear of the capture cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_q <= 8'h01;
            age_q <= 2'h0;
        end else begin
            if (reg_wr && reg_addr == 8'h08) int_q <= reg_wdata;
            if (age_q != 2'h3) age_q <= age_q + 2'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_stamp; w9 && reg_wdata[7] |=> clear_switch_stamps; endproperty
    a_stamp: assert property (p_stamp) else $error("clear pulse missing");
    property p_no_stamp; !(w9 && reg_wdata[7]) |=> !clear_switch_stamps; endproperty
    a_no_stamp: assert property (p_no_stamp) else $error("stray clear pulse");
    property p_supply; w9 |=> supply_trip_select == $past(sup_c); endproperty
    a_supply: assert property (p_supply) else $error("supply trip code wrong");
    property p_batt;
        wa |=> {battery_trip_first_select, battery_trip_second_select} == $past(bat_c);
    endproperty
    a_batt: assert property (p_batt) else $error("battery trip codes wrong");
    property p_disc; wa && reg_wdata[6] |=> battery_disconnect; endproperty
    a_disc: assert property (p_disc) else $error("disconnect not set");
    property p_reconn; supply_powerup && !(wa && reg_wdata[6]) |=> !battery_disconnect; endproperty
    a_reconn: assert property (p_reconn) else $error("disconnect not cleared");
    property p_low; 1'b1 |=> low_supply_flag == $past(low_c); endproperty
    a_low: assert property (p_low) else $error("low supply flag wrong");
    property p_trim; age_q == 2'h3 |=> $stable(trim_w); endproperty
    a_trim: assert property (p_trim) else $error("trim value moved");
    property p_off; on_battery && int_q[4] |=> !irq_fout_oe; endproperty
    a_off: assert property (p_off) else $error("pin active on battery");
    // Timer loads on the match edge, the pin enable follows one edge later
    property p_pulse;
        !quiet && int_q[5] && alarm_match |=> ##1 (irq_fout_oe || $past(quiet)) [*8];
    endproperty
    a_pulse: assert property (p_pulse) else $error("alarm pulse short");
    c_stamp: cover property (w9 && reg_wdata[7]);
    c_pulse: cover property (!quiet && int_q[5] && alarm_match);
    c_off: cover property (on_battery && int_q[4]);
endmodule : rtc_cfg_asserts

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
    localparam int PULSE = 20;
    localparam int FQ[5] = '{32768, 4096, 1024, 64, 32};
    logic clk, rst, reg_wr, reg_rd, on_battery, supply_powerup, supply_below_trip;
    logic alarm_match, alarm_flag, osc_tick, pin, irq_fout_oe, battery_disconnect;
    logic clear_switch_stamps, low_supply_flag;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] supply_trip_select, battery_trip_first_select, battery_trip_second_select;
    logic [1:0] coarse_digital_trim;
    logic [5:0] fine_analog_trim;
    int         fails = 0;
    int         num_checks = 0;
    rtc_fout_power_cfg #(.ALARM_PULSE_CYCLES(PULSE)) uut (.clk, .rst, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .osc_tick, .factory_trim(8'h9A), .on_battery,
        .supply_powerup, .supply_below_trip, .alarm_match, .alarm_flag, .irq_fout_in(pin),
        .irq_fout_out(), .irq_fout_oe, .supply_trip_select, .battery_trip_first_select,
        .battery_trip_second_select, .battery_disconnect, .clear_switch_stamps,
        .low_supply_flag, .coarse_digital_trim, .fine_analog_trim);
    board_model board (.clk, .rst, .pin_oe(irq_fout_oe), .osc_tick, .pin_level(pin));
    // ----------------------------------------------------------------
    // Access and compare tasks
    // ----------------------------------------------------------------
    function automatic logic [7:0] lim(int v, int m);
        return 8'(v > m ? m : v);
    endfunction : lim
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk
    // Resumes on the edge itself, so reads see the values that edge samples
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    // Waits one spare edge, since the read byte stands until the next read
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        step(1);
        chk($sformatf("reg %h", a), e, reg_rdata);
    endtask : rdc
    task automatic watch(input int n, output int t, output int h);
        logic p;
        p = irq_fout_oe;
        t = 0;
        h = int'(irq_fout_oe === 1'b1);
        repeat (n) begin
            step(1);
            t += int'(irq_fout_oe !== p);
            h += int'(irq_fout_oe === 1'b1);
            p = irq_fout_oe;
        end
    endtask : watch
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    // ----------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // The tests need about 41k cycles; a hang is cut at 75k cycles
    initial begin
        #600000;
        fails++;
        conclude();
    end
    initial begin
        int t, h, e;
        {reg_wr, reg_rd, on_battery, supply_powerup, supply_below_trip, alarm_match} = '0;
        {alarm_flag, rst, reg_addr, reg_wdata} = {2'h3, 16'h0000};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        step(2);
        rdc(8'h08, 8'h01);
        rdc(8'h0B, 8'h9A);
        wr(8'h0B, 8'h00);
        rdc(8'h0B, 8'h9A);
        chk("trim", 8'h9A, {coarse_digital_trim, fine_analog_trim});
        $display("test trim done");
        for (int i = 0; i < 8; i++) begin
            wr(8'h09, 8'h78 | 8'(i));
            rdc(8'h09, lim(i, 5));
            chk("supply", lim(i, 5), supply_trip_select);
            wr(8'h0A, 8'(8'h80 + i * 9));
            rdc(8'h0A, 8'(lim(i, 6) * 9));
            chk("batt", lim(i, 6) * 9,
                {battery_trip_first_select, battery_trip_second_select});
        end
        wr(8'h09, 8'h80);
        chk("clear", 1, clear_switch_stamps);
        rdc(8'h09, 8'h00);
        wr(8'h0A, 8'h40);
        chk("disconnect", 1, battery_disconnect);
        supply_powerup <= 1'b1;
        step(1);
        supply_powerup <= 1'b0;
        step(1);
        chk("reconnect", 0, battery_disconnect);
        supply_below_trip <= 1'b1;
        step(3);
        chk("low", 1, low_supply_flag);
        on_battery <= 1'b1;
        step(3);
        chk("low on battery", 0, low_supply_flag);
        $display("test power done");
        wr(8'h08, 8'h11);
        // One more edge lets the last pin value of the old code drain out
        step(1);
        watch(64, t, h);
        chk("pin off", 0, t + h);
        chk("pin level", 1, pin);
        on_battery <= 1'b0;
        alarm_flag <= 1'b0;
        wr(8'h08, 8'h20);
        step(2);
        alarm_match <= 1'b1;
        step(1);
        alarm_match <= 1'b0;
        watch(2 * PULSE, t, h);
        chk("pulse", PULSE, h);
        $display("test alarm done");
        alarm_flag <= 1'b1;
        for (int c = 1; c < 6; c++) begin
            wr(8'h08, 8'(c));
            watch(8192, t, h);
            e = FQ[c - 1] * 2 * 2048 / 65536;
            chk($sformatf("fout %0d", c), 1, t >= e - 1 && t <= e + 1);
        end
        $display("test fout done");
        conclude();
    end
endmodule : tb
bind rtc_fout_power_cfg rtc_cfg_asserts #(.ALARM_PULSE_CYCLES(ALARM_PULSE_CYCLES)) u_chk (
    .clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .on_battery, .supply_powerup,
    .supply_below_trip, .alarm_match, .irq_fout_oe, .supply_trip_select,
    .battery_trip_first_select, .battery_trip_second_select, .battery_disconnect,
    .clear_switch_stamps, .low_supply_flag, .coarse_digital_trim, .fine_analog_trim);

// ==== src/rtc_cfg_pkg.sv ====
// What this block does
// - Frequency select drives shared pin rate
// - Frequency select resets to 32768 Hz
// - Nonzero frequency select overrides alarm on pin
// - Clear-stamps write clears both switchover stamps
// - Supply trip select picks brownout level
// - Supply below trip sets low-supply flag
// - Battery disconnect bit disconnects battery input
// - Supply power-up clears disconnect, reconnects battery
// - First battery trip select, seven levels
// - Second battery trip select, seven levels
// - Initial trim loaded at power-up, read-only
// - Digital trim skips or inserts oscillator pulses
// - Coarse trim code decodes to ppm correction
// - Combined trim spans +62.5 to -61.5 ppm
// - Pin off on battery when disable set
// - Low-supply flag main-mode only, self-clearing
// - Pulse mode alarm gives 250 ms low
package rtc_cfg_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] INT_CTRL_ADDR    = 8'h08;
    localparam logic [7:0] SUPPLY_MON_ADDR  = 8'h09;
    localparam logic [7:0] BATT_TRIP_ADDR   = 8'h0A;
    localparam logic [7:0] INIT_TRIM_ADDR   = 8'h0B;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int FOUT_LSB          = 0;
    localparam int PIN_OFF_BAT_BIT   = 4;
    localparam int ALARM_PULSE_BIT   = 5;
    localparam int CLEAR_STAMPS_BIT  = 7;
    localparam int DISCONNECT_BIT    = 6;
    localparam int BATT_FIRST_LSB    = 3;
    localparam int BATT_SECOND_LSB   = 0;
    localparam int COARSE_TRIM_LSB   = 6;

    // ----------------------------------------------------------------
    // Reset values and codes
    // ----------------------------------------------------------------
    localparam logic [7:0] INT_CTRL_RESET   = 8'h01;
    localparam logic [2:0] SUPPLY_TRIP_MAX  = 3'h5;
    localparam logic [2:0] BATT_TRIP_MAX    = 3'h6;
    localparam logic [1:0] TRIM_PLUS        = 2'h1;
    localparam logic [1:0] TRIM_MINUS       = 2'h3;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS       = 8;
    localparam int ALARM_PULSE_MS      = 250;
    localparam int ALARM_PULSE_CYCLES  = ALARM_PULSE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TRIM_WINDOW_TICKS   = 32768;
    localparam int PRESCALE_W          = 21;
    localparam int ALARM_CNT_W         = 25;

    // ----------------------------------------------------------------
    // Block state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]             int_ctrl;
        logic [2:0]             supply_trip;
        logic                   battery_disconnect;
        logic [2:0]             batt_first;
        logic [2:0]             batt_second;
        logic [7:0]             init_trim;
        logic                   trim_loaded;
        logic [PRESCALE_W-1:0]  prescale;
        logic [14:0]            trim_count;
        logic                   insert_pending;
        logic [ALARM_CNT_W-1:0] alarm_count;
        logic                   pin_oe;
        logic                   low_supply;
        logic                   stamp_clear;
        logic [7:0]             rdata;
    } state_type;

endpackage : rtc_cfg_pkg

// ==== src/rtc_fout_power_cfg.sv ====
`timescale 1ns/1ps
module rtc_fout_power_cfg #(
    parameter int ALARM_PULSE_CYCLES = rtc_cfg_pkg::ALARM_PULSE_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       osc_tick,
    input  wire logic [7:0] factory_trim,
    input  wire logic       on_battery,
    input  wire logic       supply_powerup,
    input  wire logic       supply_below_trip,
    input  wire logic       alarm_match,
    input  wire logic       alarm_flag,
    input  wire logic       irq_fout_in,
    output logic            irq_fout_out,
    output logic            irq_fout_oe,
    output logic [2:0]      supply_trip_select,
    output logic [2:0]      battery_trip_first_select,
    output logic [2:0]      battery_trip_second_select,
    output logic            battery_disconnect,
    output logic            clear_switch_stamps,
    output logic            low_supply_flag,
    output logic [1:0]      coarse_digital_trim,
    output logic [5:0]      fine_analog_trim
);

    // Whole block is one state record; every output except irq_fout_out, tied low, is a flop bit of it.
    // The pin is open drain: the block only ever pulls it low and the
    // board's pull-up makes the high level. Frequency output, alarm pulse
    // and alarm level share that one enable, in that order of priority.

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------

    // Prescaler bit whose toggle gives the selected square wave
    // Bit k toggles at the tick rate over 2 to the k, so each code
    // above 4 halves the rate by moving one bit up the chain
    function automatic logic [4:0] fout_tap(input logic [3:0] code);
        logic [4:0] tap;
        tap = 5'h00;
        if (code == 4'h1) begin
            tap = 5'h00;
        end else if (code == 4'h2) begin
            tap = 5'h03;
        end else if (code == 4'h3) begin
            tap = 5'h05;
        end else begin
            tap = 5'(code) + 5'h05;
        end
        return tap;
    endfunction : fout_tap

    // Undefined trip codes fold onto the highest defined level
    // Stored clamped, so readback shows the level actually in use
    function automatic logic [2:0] clamp_trip(input logic [2:0] code, input logic [2:0] top);
        return (code > top) ? top : code;
    endfunction : clamp_trip

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    rtc_cfg_pkg::state_type state_q;
    rtc_cfg_pkg::state_type state_d;

    // Decoded views of the state, shared by next-state and pin logic
    logic [3:0] fout_code;
    logic [1:0] trim_code;
    logic       trim_wrap;
    logic       fixed_tick;
    logic       square;
    logic       pin_blocked;

    assign fout_code = state_q.int_ctrl[rtc_cfg_pkg::FOUT_LSB +: 4];
    assign trim_code = state_q.init_trim[rtc_cfg_pkg::COARSE_TRIM_LSB +: 2];
    assign trim_wrap = osc_tick && (state_q.trim_count == 15'(rtc_cfg_pkg::TRIM_WINDOW_TICKS - 1));

    // Pulse skipping drops the wrap tick, insertion adds one in a free cycle
    always_comb begin
        fixed_tick = osc_tick;
        if (trim_wrap && trim_code == rtc_cfg_pkg::TRIM_MINUS) begin
            fixed_tick = 1'b0;
        end else if (!osc_tick && state_q.insert_pending) begin
            fixed_tick = 1'b1;
        end
    end

    assign square      = state_q.prescale[fout_tap(fout_code)];
    assign pin_blocked = on_battery && state_q.int_ctrl[rtc_cfg_pkg::PIN_OFF_BAT_BIT];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.stamp_clear = 1'b0;

        // Factory trim is caught once after reset release and never written
        if (!state_q.trim_loaded) begin
            state_d.init_trim   = factory_trim;
            state_d.trim_loaded = 1'b1;
        end

        // Coarse trim correction, one pulse per 32768 ticks is 30.5 ppm
        // The trim byte never changes after capture, so no host write can
        // move the correction in the middle of a window
        if (osc_tick) begin
            state_d.trim_count = state_q.trim_count + 15'h0001;
        end
        if (trim_wrap && trim_code == rtc_cfg_pkg::TRIM_PLUS) begin
            state_d.insert_pending = 1'b1;
        end else if (!osc_tick && state_q.insert_pending) begin
            state_d.insert_pending = 1'b0;
        end
        // Codes 00 and 10 apply no correction; analog trim goes out as is
        if (fixed_tick) begin
            state_d.prescale = state_q.prescale + rtc_cfg_pkg::PRESCALE_W'(1);
        end

        // Pulse-mode alarm timer
        // A new match restarts the pulse rather than stretching it twice
        if (alarm_match && state_q.int_ctrl[rtc_cfg_pkg::ALARM_PULSE_BIT]) begin
            state_d.alarm_count = rtc_cfg_pkg::ALARM_CNT_W'(ALARM_PULSE_CYCLES);
        end else if (state_q.alarm_count != '0) begin
            state_d.alarm_count = state_q.alarm_count - rtc_cfg_pkg::ALARM_CNT_W'(1);
        end

        // Pin is open drain: enable pulls it low
        // Battery disable wins over everything, the frequency beats the alarm
        if (pin_blocked) begin
            state_d.pin_oe = 1'b0;
        end else if (fout_code != 4'h0) begin
            state_d.pin_oe = ~square;
        end else if (state_q.int_ctrl[rtc_cfg_pkg::ALARM_PULSE_BIT]) begin
            state_d.pin_oe = (state_q.alarm_count != '0);
        end else begin
            state_d.pin_oe = alarm_flag;
        end

        // Comparator result only counts while running from main supply
        state_d.low_supply = supply_below_trip && !on_battery;

        // Returning main supply reconnects the battery
        if (supply_powerup) begin
            state_d.battery_disconnect = 1'b0;
        end

        // Register writes; host write to disconnect beats power-up clear
        // Trip codes are clamped on the way in; the trim offset takes no write
        if (reg_wr) begin
            if (reg_addr == rtc_cfg_pkg::INT_CTRL_ADDR) begin
                state_d.int_ctrl = reg_wdata;
            end else if (reg_addr == rtc_cfg_pkg::SUPPLY_MON_ADDR) begin
                state_d.stamp_clear = reg_wdata[rtc_cfg_pkg::CLEAR_STAMPS_BIT];
                state_d.supply_trip = clamp_trip(reg_wdata[2:0],
                                                 rtc_cfg_pkg::SUPPLY_TRIP_MAX);
            end else if (reg_addr == rtc_cfg_pkg::BATT_TRIP_ADDR) begin
                if (reg_wdata[rtc_cfg_pkg::DISCONNECT_BIT]) begin
                    state_d.battery_disconnect = 1'b1;
                end
                state_d.batt_first  = clamp_trip(reg_wdata[rtc_cfg_pkg::BATT_FIRST_LSB +: 3],
                                                 rtc_cfg_pkg::BATT_TRIP_MAX);
                state_d.batt_second = clamp_trip(reg_wdata[rtc_cfg_pkg::BATT_SECOND_LSB +: 3],
                                                 rtc_cfg_pkg::BATT_TRIP_MAX);
            end
        end

        // Read data, registered one cycle after the strobe
        // Bits with no storage read as zero, unmapped offsets give 00h
        if (reg_rd) begin
            if (reg_addr == rtc_cfg_pkg::INT_CTRL_ADDR) begin
                state_d.rdata = state_q.int_ctrl;
            end else if (reg_addr == rtc_cfg_pkg::SUPPLY_MON_ADDR) begin
                state_d.rdata = {5'h00, state_q.supply_trip};
            end else if (reg_addr == rtc_cfg_pkg::BATT_TRIP_ADDR) begin
                state_d.rdata = {1'b0, state_q.battery_disconnect,
                                 state_q.batt_first, state_q.batt_second};
            end else if (reg_addr == rtc_cfg_pkg::INIT_TRIM_ADDR) begin
                state_d.rdata = state_q.init_trim;
            end else begin
                state_d.rdata = 8'h00;
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Only constants in the reset branch; the factory trim is caught on
    // the first clock after release instead, once its input has settled.
    // Frequency output comes up on the fastest rate straight from reset.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q          <= '0;
            state_q.int_ctrl <= rtc_cfg_pkg::INT_CTRL_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from state flops except irq_fout_out, tied low
    // ----------------------------------------------------------------
    assign reg_rdata                  = state_q.rdata;
    assign irq_fout_out               = 1'b0;
    assign irq_fout_oe                = state_q.pin_oe;
    assign supply_trip_select         = state_q.supply_trip;
    assign battery_trip_first_select  = state_q.batt_first;
    assign battery_trip_second_select = state_q.batt_second;
    assign battery_disconnect         = state_q.battery_disconnect;
    assign clear_switch_stamps        = state_q.stamp_clear;
    assign low_supply_flag            = state_q.low_supply;
    // Analog trim spans +32..-31 ppm; with coarse step it covers +62.5..-61.5
    // Both trim fields leave as captured; the oscillator applies the analog part
    assign coarse_digital_trim        = trim_code;
    assign fine_analog_trim           = state_q.init_trim[5:0];

endmodule : rtc_fout_power_cfg
